// [include/dma_lo_map.svh]
// Offsets, field positions, reset values and timing counts of the lower DMA group.
// Assumes an 8-bit I/O port space decoded on io_addr_in[7:0].
`ifndef DMA_LO_MAP_SVH
`define DMA_LO_MAP_SVH

// I/O locations
`define DLO_CHAN_PORT_MASK 8'hF8
`define DLO_CHAN_PORT_BASE 8'h00
`define DLO_PORT_CHAN_HI 2
`define DLO_PORT_CHAN_LO 1
`define DLO_PORT_KIND_BIT 0
`define DLO_ADDR_STATUS_CMD 8'h08
`define DLO_ADDR_SOFT_REQ 8'h09
`define DLO_ADDR_SINGLE_MASK 8'h0A
`define DLO_ADDR_CLR_PTR 8'h0C
`define DLO_ADDR_CLR_MASK 8'h0E

// Command byte fields
`define DLO_CMD_ACK_POL 7
`define DLO_CMD_REQ_POL 6
`define DLO_CMD_WR_TIMING 5
`define DLO_CMD_ARB 4
`define DLO_CMD_COMPRESS 3
`define DLO_CMD_DISABLE 2

// Software request and single mask fields
`define DLO_SEL_BIT 2
`define DLO_CHAN_SEL_HI 1
`define DLO_CHAN_SEL_LO 0

// Reset values
`define DLO_CMD_RESET 8'h00
`define DLO_STATUS_RESET 8'h00
`define DLO_MASK_RESET 4'hF
`define DLO_MIRROR_RESET 16'h00FF
`define DLO_MIRROR_UPPER 8'h00
`define DLO_WORD_RESET 16'h0000
`define DLO_READ_IDLE 8'h00
`define DLO_ACK_IDLE_LOW 4'hF

// Transfer phase lengths in clock cycles
`define DLO_XFER_NORMAL 2'h2
`define DLO_XFER_COMPRESSED 2'h1
`define DLO_XFER_LAST 2'h1

`endif

// [include/dma_lo_pkg.sv]
// Types shared by the lower DMA group register block and its transfer engine.
// Assumes dma_lo_map.svh supplies all numeric constants.
package dma_lo_pkg;

   // Transfer engine states, Gray coded along idle-addr-xfer-done
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_XFER = 2'b11,
      ST_DONE = 2'b10
   } xfer_state_t;

   typedef logic [1:0] chan_sel_t;

endpackage : dma_lo_pkg

// [include/dma_lo_if.sv]
// Link between the lower DMA register block and its transfer engine.
// Assumes both ends share sys_clk_in.
`timescale 1ns/1ps
interface dma_lo_if;
   logic [3:0] eligible;
   logic rotate;
   logic compressed;
   logic extended_wr;
   logic ack_high;
   logic busy;
   dma_lo_pkg::chan_sel_t chan;
   logic [3:0] dack;
   logic strobe_rd;
   logic strobe_wr;
   logic done;

   modport regs (output eligible, output rotate, output compressed, output extended_wr,
      output ack_high, input busy, input chan, input dack, input strobe_rd,
      input strobe_wr, input done);
   modport engine (input eligible, input rotate, input compressed, input extended_wr,
      input ack_high, output busy, output chan, output dack, output strobe_rd,
      output strobe_wr, output done);
endinterface : dma_lo_if

// [core/dma_lo_engine.sv]
// Arbitration and transfer timing for channels 0 to 3.
// Assumes eligible already folds in masks, disable and request polarity.
`timescale 1ns/1ps
`include "dma_lo_map.svh"
module dma_lo_engine (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   dma_lo_if.engine eng
);
   dma_lo_pkg::xfer_state_t state;
   dma_lo_pkg::xfer_state_t next_state;
   dma_lo_pkg::chan_sel_t prio_base;
   dma_lo_pkg::chan_sel_t pick;
   dma_lo_pkg::chan_sel_t next_chan;
   logic found;
   logic [1:0] phase_cnt;
   logic [3:0] next_sel;

   // Priority search starting at the current top channel
   always_comb begin
      dma_lo_pkg::chan_sel_t idx;
      idx = prio_base;
      pick = prio_base;
      found = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         idx = prio_base + 2'(i);
         if (eng.eligible[idx]) begin
            pick = idx;
            found = 1'b1;
         end
      end
   end

   // Next state; a transfer in flight always completes
   always_comb begin
      next_state = state;
      next_chan = eng.chan;
      unique case (state)
         dma_lo_pkg::ST_IDLE: begin
            if (found) begin
               next_state = dma_lo_pkg::ST_ADDR;
               next_chan = pick;
            end
         end
         dma_lo_pkg::ST_ADDR: next_state = dma_lo_pkg::ST_XFER;
         dma_lo_pkg::ST_XFER: begin
            if (phase_cnt == `DLO_XFER_LAST) begin
               next_state = dma_lo_pkg::ST_DONE;
            end
         end
         dma_lo_pkg::ST_DONE: next_state = dma_lo_pkg::ST_IDLE;
      endcase
   end

   always_comb begin
      next_sel = 4'h0;
      if (next_state == dma_lo_pkg::ST_ADDR || next_state == dma_lo_pkg::ST_XFER) begin
         next_sel[next_chan] = 1'b1;
      end
   end

   // State, channel and phase counter
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= dma_lo_pkg::ST_IDLE;
         eng.chan <= 2'h0;
         phase_cnt <= `DLO_XFER_NORMAL;
      end else begin
         state <= next_state;
         eng.chan <= next_chan;
         if (state == dma_lo_pkg::ST_ADDR) begin
            phase_cnt <= eng.compressed ? `DLO_XFER_COMPRESSED : `DLO_XFER_NORMAL;
         end else if (state == dma_lo_pkg::ST_XFER) begin
            phase_cnt <= phase_cnt - 2'h1;
         end
      end
   end

   // Top priority: fixed keeps channel 0 first, rotating demotes the served one
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prio_base <= 2'h0;
      end else if (!eng.rotate) begin
         prio_base <= 2'h0;
      end else if (state == dma_lo_pkg::ST_DONE) begin
         prio_base <= eng.chan + 2'h1;
      end
   end

   // Acknowledge and strobes, registered so pins never glitch
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         eng.dack <= `DLO_ACK_IDLE_LOW;
         eng.strobe_rd <= 1'b0;
         eng.strobe_wr <= 1'b0;
         eng.done <= 1'b0;
         eng.busy <= 1'b0;
      end else begin
         eng.dack <= eng.ack_high ? next_sel : ~next_sel;
         eng.strobe_rd <= next_state == dma_lo_pkg::ST_XFER;
         // Extended write opens the strobe one cycle early
         eng.strobe_wr <= (next_state == dma_lo_pkg::ST_XFER) ||
            (eng.extended_wr && next_state == dma_lo_pkg::ST_ADDR);
         eng.done <= next_state == dma_lo_pkg::ST_DONE;
         eng.busy <= next_state != dma_lo_pkg::ST_IDLE;
      end
   end

endmodule : dma_lo_engine

// [core/dma_lo_regs.sv]
// Programming interface of the lower four-channel DMA group, with its engine.
// Assumes the I/O bus strobes are one-cycle pulses on sys_clk_in.
//
// What this block does
// - Mask mirror bits 7..0 show channel 7..0 mask, 1 means masked.
// - Mask mirror bits 15..8 always read zero.
// - 16-bit address and count use one byte port, low byte then high.
// - Address ports of channels 0..3 sit at 000h, 002h, 004h, 006h.
// - Count ports of channels 0..3 sit at 001h, 003h, 005h, 007h.
// - Reading 008h gives status, zero after reset; bits 7..4 pending requests.
// - Status bits 3..0 flag terminal count reached on channels 3..0.
// - Writing 008h loads the command byte instead of status.
// - Command bit 7 sets acknowledge polarity, 1 active high.
// - Command bit 6 sets request polarity, 1 active low.
// - Command bit 5 picks late write or extended write strobe.
// - Command bit 4 picks fixed or rotating priority.
// - Command bit 3 picks normal or compressed transfer timing.
// - Command bit 2 set stops servicing all four channels.
// - Write 009h with bit 2 set raises software request on selected channel.
// - Write 00Ah with bit 2 set masks the selected channel.
// - Any write to 00Ch returns the byte pointer to low byte.
// - Any write to 00Eh clears masks of channels 0..3.
`timescale 1ns/1ps
`include "dma_lo_map.svh"
module dma_lo_regs (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   output logic [7:0] io_rdata_out,
   input wire logic [3:0] dreq_in,
   input wire logic [3:0] upper_mask_in,
   output logic [3:0] dack_out,
   output logic [15:0] mem_addr_out,
   output logic mem_rd_strobe_out,
   output logic mem_wr_strobe_out,
   output logic [3:0] tc_out,
   output logic [15:0] mask_mirror_out
);
   dma_lo_if link ();

   logic [7:0] command;
   logic [3:0] mask;
   logic [3:0] soft_req;
   logic [3:0] tc_flag;
   logic [3:0] dreq_meta;
   logic [3:0] dreq_sync;
   logic [3:0] hw_req;
   logic [3:0] pending;
   logic byte_ptr;
   logic [15:0] cur_addr [4];
   logic [15:0] cur_cnt [4];
   logic chan_port_hit;
   dma_lo_pkg::chan_sel_t port_chan;
   dma_lo_pkg::chan_sel_t wr_sel;
   logic port_is_count;
   logic chan_wr;
   logic chan_rd;
   logic cmd_wr;
   logic soft_wr;
   logic mask_wr;
   logic clr_ptr_wr;
   logic clr_mask_wr;
   logic status_rd;
   logic [15:0] port_word;

   // Port decode: channel ports fill 000h..007h, kind in bit 0
   assign chan_port_hit = (io_addr_in & `DLO_CHAN_PORT_MASK) == `DLO_CHAN_PORT_BASE;
   assign port_chan = io_addr_in[`DLO_PORT_CHAN_HI:`DLO_PORT_CHAN_LO];
   assign port_is_count = io_addr_in[`DLO_PORT_KIND_BIT];
   assign chan_wr = io_wr_in && chan_port_hit;
   assign chan_rd = io_rd_in && chan_port_hit;
   assign cmd_wr = io_wr_in && io_addr_in == `DLO_ADDR_STATUS_CMD;
   assign status_rd = io_rd_in && io_addr_in == `DLO_ADDR_STATUS_CMD;
   assign soft_wr = io_wr_in && io_addr_in == `DLO_ADDR_SOFT_REQ;
   assign mask_wr = io_wr_in && io_addr_in == `DLO_ADDR_SINGLE_MASK;
   assign clr_ptr_wr = io_wr_in && io_addr_in == `DLO_ADDR_CLR_PTR;
   assign clr_mask_wr = io_wr_in && io_addr_in == `DLO_ADDR_CLR_MASK;
   assign wr_sel = io_wdata_in[`DLO_CHAN_SEL_HI:`DLO_CHAN_SEL_LO];
   assign port_word = port_is_count ? cur_cnt[port_chan] : cur_addr[port_chan];

   // Request pins come from outside the clock domain
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dreq_meta <= 4'h0;
         dreq_sync <= 4'h0;
      end else begin
         dreq_meta <= dreq_in;
         dreq_sync <= dreq_meta;
      end
   end

   // Polarity, masking and global disable fold into one eligibility word
   assign hw_req = dreq_sync ^ {4{command[`DLO_CMD_REQ_POL]}};
   assign pending = hw_req | soft_req;
   assign link.eligible = pending & ~mask & {4{~command[`DLO_CMD_DISABLE]}};
   assign link.rotate = command[`DLO_CMD_ARB];
   assign link.compressed = command[`DLO_CMD_COMPRESS];
   assign link.extended_wr = command[`DLO_CMD_WR_TIMING];
   assign link.ack_high = command[`DLO_CMD_ACK_POL];

   // Command byte; bit 0 is stored as written, software keeps it 0
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         command <= `DLO_CMD_RESET;
      end else if (cmd_wr) begin
         command <= io_wdata_in;
      end
   end

   // Shared low/high pointer, flips on every channel port access
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         byte_ptr <= 1'b0;
      end else if (clr_ptr_wr) begin
         byte_ptr <= 1'b0;
      end else if (chan_wr || chan_rd) begin
         byte_ptr <= ~byte_ptr;
      end
   end

   // Per-channel word registers, mask, software request and count flag
   for (genvar g = 0; g < 4; g++) begin : g_chan
      logic hit_here;
      logic served;
      assign hit_here = chan_wr && port_chan == dma_lo_pkg::chan_sel_t'(g);
      assign served = link.done && link.chan == dma_lo_pkg::chan_sel_t'(g);

      // Host write wins over a transfer update in the same cycle
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            cur_addr[g] <= `DLO_WORD_RESET;
            cur_cnt[g] <= `DLO_WORD_RESET;
         end else if (hit_here) begin
            if (!port_is_count && !byte_ptr) begin
               cur_addr[g][7:0] <= io_wdata_in;
            end
            if (!port_is_count && byte_ptr) begin
               cur_addr[g][15:8] <= io_wdata_in;
            end
            if (port_is_count && !byte_ptr) begin
               cur_cnt[g][7:0] <= io_wdata_in;
            end
            if (port_is_count && byte_ptr) begin
               cur_cnt[g][15:8] <= io_wdata_in;
            end
         end else if (served) begin
            cur_addr[g] <= cur_addr[g] + 16'h0001;
            cur_cnt[g] <= cur_cnt[g] - 16'h0001;
         end
      end

      // Single-channel port beats the clear-all port; both cannot coincide anyway
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            mask[g] <= 1'(`DLO_MASK_RESET >> g); // One bit of the reset mask per channel
         end else if (mask_wr && wr_sel == dma_lo_pkg::chan_sel_t'(g)) begin
            mask[g] <= io_wdata_in[`DLO_SEL_BIT];
         end else if (clr_mask_wr) begin
            mask[g] <= 1'b0;
         end
      end

      // Terminal count retires a software request; a new write still wins
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            soft_req[g] <= 1'b0;
         end else if (soft_wr && wr_sel == dma_lo_pkg::chan_sel_t'(g)) begin
            soft_req[g] <= io_wdata_in[`DLO_SEL_BIT];
         end else if (served && cur_cnt[g] == `DLO_WORD_RESET) begin
            soft_req[g] <= 1'b0;
         end
      end

      // Count flag: set beats the clear-on-status-read
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            tc_flag[g] <= 1'b0;
            tc_out[g] <= 1'b0;
         end else begin
            tc_out[g] <= served && cur_cnt[g] == `DLO_WORD_RESET;
            if (served && cur_cnt[g] == `DLO_WORD_RESET) begin
               tc_flag[g] <= 1'b1;
            end else if (status_rd) begin
               tc_flag[g] <= 1'b0;
            end
         end
      end
   end

   // Read data holds until the next read; unmapped reads give zero
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         io_rdata_out <= `DLO_READ_IDLE;
      end else if (status_rd) begin
         io_rdata_out <= {pending, tc_flag};
      end else if (chan_rd) begin
         io_rdata_out <= byte_ptr ? port_word[15:8] : port_word[7:0];
      end else if (io_rd_in) begin
         io_rdata_out <= `DLO_READ_IDLE;
      end
   end

   // Mirror of all eight masks; upper group comes from same-clock logic
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mask_mirror_out <= `DLO_MIRROR_RESET;
      end else begin
         mask_mirror_out <= {`DLO_MIRROR_UPPER, upper_mask_in, mask};
      end
   end

   // Address of the channel currently granted
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mem_addr_out <= `DLO_WORD_RESET;
      end else begin
         mem_addr_out <= cur_addr[link.chan];
      end
   end

   // Engine outputs are flip-flops inside the engine
   assign dack_out = link.dack;
   assign mem_rd_strobe_out = link.strobe_rd;
   assign mem_wr_strobe_out = link.strobe_wr;

   dma_lo_engine u_engine (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .eng(link.engine)
   );

endmodule : dma_lo_regs

// [bench/dma_lo_regs_props.sv]
// Checker on the top ports of the lower DMA register block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module dma_lo_regs_props (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic [3:0] upper_mask_in,
   input wire logic [3:0] dack_out,
   input wire logic mem_rd_strobe_out,
   input wire logic mem_wr_strobe_out,
   input wire logic [3:0] tc_out,
   input wire logic [15:0] mask_mirror_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   // Idle is all ones or all zeros, so anything else is a live grant
   wire logic granted = (dack_out != 4'hF) && (dack_out != 4'h0);
   sequence grant_start;
      $rose(granted);
   endsequence
   sequence xfer_pair;
      mem_rd_strobe_out ##1 mem_rd_strobe_out;
   endsequence
   upper_zero_a: assert property (mask_mirror_out[15:8] == 8'h00)
      else $error("mirror upper byte not zero");
   upper_follow_a: assert property ($past(rst_b_in) |->
      mask_mirror_out[7:4] == $past(upper_mask_in)) else $error("mirror upper masks stale");
   wo_read_zero_a: assert property (io_rd_in && io_addr_in >= 8'h09 |=>
      io_rdata_out == 8'h00) else $error("write-only read not zero");
   rdata_hold_a: assert property (!io_rd_in |=> $stable(io_rdata_out))
      else $error("read data moved without read");
   grant_phase_a: assert property (grant_start |-> !mem_rd_strobe_out ##1 mem_rd_strobe_out)
      else $error("address phase not one cycle");
   strobe_max_a: assert property (xfer_pair |=> !mem_rd_strobe_out)
      else $error("transfer phase too long");
   rd_grant_a: assert property (mem_rd_strobe_out |-> granted && mem_wr_strobe_out)
      else $error("strobe without grant");
   ext_write_a: assert property (mem_wr_strobe_out && !mem_rd_strobe_out |=>
      mem_rd_strobe_out) else $error("early write not followed by transfer");
   tc_pulse_a: assert property (tc_out != 4'h0 |=> tc_out == 4'h0)
      else $error("terminal count pulse too long");
endmodule : dma_lo_regs_props

bind dma_lo_regs dma_lo_regs_props dma_lo_regs_props_i (.sys_clk_in, .rst_b_in, .io_addr_in,
   .io_rd_in, .io_rdata_out, .upper_mask_in, .dack_out, .mem_rd_strobe_out,
   .mem_wr_strobe_out, .tc_out, .mask_mirror_out);

// [bench/dma_lo_requester.sv]
// Four peripheral requesters facing the lower DMA group.
// Assumes the bench mirrors the polarity bits of the command it wrote.
`timescale 1ns/1ps
module dma_lo_requester (
   input wire logic sys_clk_in,
   input wire logic [3:0] want_in,
   input wire logic req_low_in,
   input wire logic ack_high_in,
   input wire logic [3:0] dack_in,
   output logic [3:0] dreq_out
);
   logic [3:0] pend = 4'h0;
   // A one-shot request drops once its acknowledge is seen
   always_ff @(posedge sys_clk_in) begin
      pend <= want_in | (pend & ~(ack_high_in ? dack_in : ~dack_in));
   end
   // Line level follows the programmed request sense
   assign dreq_out = pend ^ {4{req_low_in}};
endmodule : dma_lo_requester

// [bench/slave_dma_channel_regs_bench.sv]
// Self-checking bench for the lower DMA group register block.
// Assumes the requester model drives dreq_in and watches dack_out.
`timescale 1ns/1ps
module slave_dma_channel_regs_bench;
   logic sys_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] io_addr = 8'h00;
   logic [7:0] io_wdata = 8'h00;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [3:0] upper_mask = 4'hA;
   logic [3:0] want = 4'h0;
   logic req_low = 1'b0;
   logic ack_high = 1'b0;
   logic [7:0] io_rdata_out;
   logic [3:0] dreq, dack_out, tc_out;
   logic [15:0] mem_addr_out, mask_mirror_out;
   logic rds, wrs;
   int failures = 0;
   int checks_done = 0;
   wire logic [3:0] idle = ack_high ? 4'h0 : 4'hF;
   initial begin
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   dma_lo_requester dma_lo_requester_i (.sys_clk_in, .want_in(want), .req_low_in(req_low),
      .ack_high_in(ack_high), .dack_in(dack_out), .dreq_out(dreq));
   dma_lo_regs dma_lo_regs_i (.sys_clk_in, .rst_b_in, .io_addr_in(io_addr),
      .io_wdata_in(io_wdata), .io_wr_in(io_wr), .io_rd_in(io_rd), .io_rdata_out,
      .dreq_in(dreq), .upper_mask_in(upper_mask), .dack_out, .mem_addr_out,
      .mem_rd_strobe_out(rds), .mem_wr_strobe_out(wrs), .tc_out, .mask_mirror_out);
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge sys_clk_in);
      io_wr = 1'b0;
   endtask : wr8
   task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk_in);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge sys_clk_in);
      io_rd = 1'b0;
      @(negedge sys_clk_in);
      check("io_rdata_out", {8'h00, exp}, {8'h00, io_rdata_out});
   endtask : rd8
   // Sense changes pass through a disabled window so stray levels start nothing
   task automatic cmd(input logic [7:0] v);
      wr8(8'h08, v | 8'h04);
      ack_high = v[7];
      req_low = v[6];
      repeat (4) @(negedge sys_clk_in);
      wr8(8'h08, v);
   endtask : cmd
   task automatic next_grant(output logic [3:0] g);
      int n;
      n = 0;
      while (dack_out !== idle && n < 60) begin
         @(negedge sys_clk_in);
         n++;
      end
      while (dack_out === idle && n < 60) begin
         @(negedge sys_clk_in);
         n++;
      end
      if (n == 60) begin
         failures++;
         $display("mismatch dack_out expected grant seen %h", dack_out);
         test_done();
      end
      g = dack_out;
   endtask : next_grant
   task automatic no_grant();
      repeat (20) begin
         @(negedge sys_clk_in);
         check("dack_out idle", 16'(idle), 16'(dack_out));
      end
   endtask : no_grant
   task automatic t_reset();
      repeat (6) @(negedge sys_clk_in);
      check("mask_mirror_out", 16'h00FF, mask_mirror_out);
      rst_b_in = 1'b1;
      @(negedge sys_clk_in);
      check("mask_mirror_out", {8'h00, upper_mask, 4'hF}, mask_mirror_out);
      rd8(8'h08, 8'h00);
      $display("test reset done");
   endtask : t_reset
   // Even ports hold addresses, odd ports counts; all bytes distinct
   task automatic t_ports();
      wr8(8'h0C, 8'h5A);
      for (int c = 0; c < 8; c++) begin
         wr8(8'(c), 8'(c + 1));
         wr8(8'(c), 8'(c + 17));
      end
      for (int c = 0; c < 8; c++) begin
         rd8(8'(c), 8'(c + 1));
         rd8(8'(c), 8'(c + 17));
      end
      wr8(8'h00, 8'hEE);
      wr8(8'h0C, 8'h00);
      wr8(8'h00, 8'h34);
      wr8(8'h00, 8'h12);
      rd8(8'h00, 8'h34);
      rd8(8'h00, 8'h12);
      rd8(8'h0A, 8'h00);
      rd8(8'h0B, 8'h00);
      $display("test ports done");
   endtask : t_ports
   task automatic t_mask();
      logic [3:0] g;
      wr8(8'h0E, 8'hFF);
      @(negedge sys_clk_in);
      check("mask_mirror_out", 16'h00A0, mask_mirror_out);
      upper_mask = 4'h5;
      wr8(8'h0A, 8'hFE);
      @(negedge sys_clk_in);
      check("mask_mirror_out", 16'h0054, mask_mirror_out);
      wr8(8'h0A, 8'hFA);
      @(negedge sys_clk_in);
      check("mask_mirror_out", 16'h0050, mask_mirror_out);
      wr8(8'h0A, 8'h07);
      want = 4'h8;
      no_grant();
      wr8(8'h0A, 8'h03);
      next_grant(g);
      want = 4'h0;
      check("dack_out", 16'h0007, 16'(g));
      $display("test mask done");
   endtask : t_mask
   task automatic t_soft();
      logic [3:0] g;
      int n;
      wr8(8'h0C, 8'h00);
      wr8(8'h02, 8'h34);
      wr8(8'h02, 8'h12);
      wr8(8'h03, 8'h00);
      wr8(8'h03, 8'h00);
      wr8(8'h09, 8'hFD);
      next_grant(g);
      check("dack_out", 16'h000D, 16'(g));
      @(negedge sys_clk_in);
      check("mem_addr_out", 16'h1234, mem_addr_out);
      n = 0;
      while (tc_out === 4'h0 && n < 20) begin
         @(negedge sys_clk_in);
         n++;
      end
      check("tc_out", 16'h0002, 16'(tc_out));
      rd8(8'h08, 8'h02);
      rd8(8'h08, 8'h00);
      cmd(8'h04);
      wr8(8'h09, 8'h04);
      no_grant();
      rd8(8'h08, 8'h10);
      cmd(8'h00);
      next_grant(g);
      check("dack_out", 16'h000E, 16'(g));
      wr8(8'h09, 8'h00);
      repeat (8) @(negedge sys_clk_in);
      rd8(8'h08, 8'h00);
      cmd(8'hC0);
      want = 4'h4;
      next_grant(g);
      want = 4'h0;
      check("dack_out", 16'h0004, 16'(g));
      $display("test soft done");
   endtask : t_soft
   // Strobe cycles per grant for normal, compressed and extended settings
   task automatic t_timing();
      logic [3:0] g, h;
      logic [7:0] modes [3] = '{8'h00, 8'h08, 8'h20};
      int r, w;
      want = 4'h5;
      for (int m = 0; m < 3; m++) begin
         cmd(modes[m]);
         next_grant(g);
         check("fixed grant", 16'h000E, 16'(g));
         r = 0;
         w = 0;
         repeat (4) begin
            r += int'(rds);
            w += int'(wrs);
            @(negedge sys_clk_in);
         end
         check("read strobes", modes[m][3] ? 16'h0001 : 16'h0002, 16'(r));
         check("write strobes", 16'(r + int'(modes[m][5])), 16'(w));
      end
      cmd(8'h10);
      next_grant(g);
      next_grant(h);
      check("rotating grant", 16'(g ^ 4'h5), 16'(h));
      want = 4'h0;
      $display("test timing done");
   endtask : t_timing
   initial begin
      t_reset();
      t_ports();
      t_mask();
      t_soft();
      t_timing();
      test_done();
   end
endmodule : slave_dma_channel_regs_bench
